// [src/tbp_top.sv]
// Timer bus interface: configuration, time-base readout, prescaler, interrupt arbitration.
// Assumes a same-clock register master; FREEZE, TEST_MODE and EXT_CLK_IN are asynchronous pins.
module tbp_top import tbp_pkg::*; (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [AW-1:0] ADDR,
    input wire logic [DW-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [DW-1:0] RDATA,
    input wire logic FREEZE,
    input wire logic TEST_MODE,
    input wire logic EXT_CLK_IN,
    input wire logic [NTB-1:0][DW-1:0] TB_BUS,
    input tbp_sub_t [NSUB-1:0] SUB,
    input tbp_ackcyc_t ACK_CYC,
    output logic [TAP_N-1:0] TAPS,
    output logic [6:0] IRQ,
    output tbp_resp_t RESP
);
    // ==========================================================
    // Pin synchronisers
    logic frz_m_r, frz_r, tst_m_r, tst_r, ext_m_r, ext_r, ext_d_r;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            frz_m_r <= 1'b0;
            frz_r <= 1'b0;
            tst_m_r <= 1'b0;
            tst_r <= 1'b0;
            ext_m_r <= 1'b0;
            ext_r <= 1'b0;
            ext_d_r <= 1'b0;
        end else begin
            frz_m_r <= FREEZE;
            frz_r <= frz_m_r;
            tst_m_r <= TEST_MODE;
            tst_r <= tst_m_r;
            ext_m_r <= EXT_CLK_IN;
            ext_r <= ext_m_r;
            ext_d_r <= ext_r;
        end
    end

    // ==========================================================
    // Register file
    logic [DW-1:0] cfg_r, cfg_nxt;
    logic [3:0] ctl_r, ctl_nxt;
    logic [DW-1:0] readout_r, readout_nxt;
    logic hold_r, hold_nxt;
    logic ext_fall_r, ext_fall_nxt;
    logic [1:0] bus_sel;
    logic [2:0] arb_id;
    logic [1:0] vec_base;
    logic [DW-1:0] tb_view;

    always_comb begin
        bus_sel = {cfg_r[CFG_SEL_HI], cfg_r[CFG_SEL_LO]};
        arb_id = cfg_r[CFG_ARB_LSB +: 3];
        vec_base = cfg_r[CFG_VEC_LSB +: 2];
        tb_view = hold_r ? readout_r : TB_BUS[bus_sel];
        cfg_nxt = cfg_r;
        ctl_nxt = ctl_r;
        readout_nxt = readout_r;
        hold_nxt = hold_r && tst_r;
        ext_fall_nxt = ext_fall_r;
        // Writes are taken regardless of freeze
        if (WR) begin
            unique case (ADDR)
                OFS_CONFIG: cfg_nxt = WDATA & CFG_WMASK;
                OFS_CONTROL: ctl_nxt = WDATA[3:0];
                OFS_EXTSRC: ext_fall_nxt = WDATA[0];
                OFS_READOUT: begin
                    if (tst_r) begin
                        readout_nxt = WDATA;
                        hold_nxt = 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg_r <= CFG_RST;
            ctl_r <= CTL_RST;
            readout_r <= READOUT_RST;
            hold_r <= 1'b0;
            ext_fall_r <= EXT_RST;
        end else begin
            cfg_r <= cfg_nxt;
            ctl_r <= ctl_nxt;
            readout_r <= readout_nxt;
            hold_r <= hold_nxt;
            ext_fall_r <= ext_fall_nxt;
        end
    end

    // ==========================================================
    // Prescaler and arbiter
    logic [5:0] ps_taps;
    tbp_resp_t arb_resp;

    tbp_prescaler u_prescaler (
        .clk(CLK),
        .reset_n(RESET_N),
        .run(ctl_r[CTL_RUN]),
        .ratio3(ctl_r[CTL_RATIO]),
        .psel(ctl_r[CTL_PSEL_LSB +: 2]),
        .frozen(frz_r),
        .taps(ps_taps)
    );

    tbp_arbiter u_arbiter (
        .subs(SUB),
        .ack_cyc(ACK_CYC),
        .arb_id(arb_id),
        .vec_base(vec_base),
        .resp(arb_resp)
    );

    // ==========================================================
    // Output registers
    logic [DW-1:0] rdata_r, rdata_nxt;
    logic [TAP_N-1:0] taps_r, taps_nxt;
    logic [6:0] irq_r, irq_nxt;
    tbp_resp_t resp_r, resp_nxt;
    logic ext_edge;

    always_comb begin
        rdata_nxt = '0;
        // Reserved locations and the test register read as zero
        if (RD) begin
            unique case (ADDR)
                OFS_CONFIG: rdata_nxt = cfg_r;
                OFS_READOUT: rdata_nxt = tb_view;
                OFS_CONTROL: rdata_nxt = {12'h000, ctl_r};
                OFS_EXTSRC: rdata_nxt = {15'h0000, ext_fall_r};
                default: rdata_nxt = '0;
            endcase
        end
        ext_edge = ext_fall_r ? (ext_d_r && !ext_r) : (!ext_d_r && ext_r);
        taps_nxt = {ext_edge, ps_taps};
        for (int l = 1; l < 8; l++) begin
            irq_nxt[l-1] = 1'b0;
            for (int i = 0; i < NSUB; i++) begin
                if (sub_wants(SUB[i], 3'(l))) begin
                    irq_nxt[l-1] = 1'b1;
                end
            end
        end
        resp_nxt = arb_resp;
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_r <= '0;
            taps_r <= '0;
            irq_r <= '0;
            resp_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
            taps_r <= taps_nxt;
            irq_r <= irq_nxt;
            resp_r <= resp_nxt;
        end
    end

    assign RDATA = rdata_r;
    assign TAPS = taps_r;
    assign IRQ = irq_r;
    assign RESP = resp_r;

    // ==========================================================
    // Checks
    sequence s_ratio2_running;
        ctl_r[CTL_RUN] && !ctl_r[CTL_RATIO] && !frz_r;
    endsequence

    sequence s_first_tap_start;
        TAPS[0] ##0 s_ratio2_running;
    endsequence

    a_readout_selects_bus: assert property (@(posedge CLK) disable iff (!RESET_N)
        (RD && ADDR == OFS_READOUT && !hold_r) |=> RDATA == $past(TB_BUS[bus_sel]))
        else $error("readout did not return the selected bus");

    a_readout_write_ignored: assert property (@(posedge CLK) disable iff (!RESET_N)
        (WR && ADDR == OFS_READOUT && !tst_r) |=> $stable(readout_r) && !hold_r)
        else $error("readout changed on a normal write");

    a_reserved_reads_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
        (RD && (ADDR == OFS_TEST || ADDR == OFS_RSV0 || ADDR == OFS_RSV1)) |=> RDATA == '0)
        else $error("reserved location read nonzero");

    a_control_readback: assert property (@(posedge CLK) disable iff (!RESET_N)
        (WR && ADDR == OFS_CONTROL) ##1 (RD && ADDR == OFS_CONTROL)
        |=> RDATA == {12'h000, $past(WDATA[3:0], 2)})
        else $error("control readback wrong");

    a_stopped_taps_idle: assert property (@(posedge CLK) disable iff (!RESET_N)
        !ctl_r[CTL_RUN] |=> TAPS[5:0] == 6'h00)
        else $error("tap fired while stopped");

    a_first_tap_period: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_first_tap_start ##1 s_ratio2_running |-> !TAPS[0] ##1 TAPS[0])
        else $error("first tap not every second cycle");

    a_no_arb_when_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
        (ACK_CYC.valid && arb_id == 3'h0) |=> !RESP.hit)
        else $error("responded with arbitration field zero");

    a_vector_base_bits: assert property (@(posedge CLK) disable iff (!RESET_N)
        RESP.hit |-> RESP.vector[7:6] == $past(vec_base) && $past(ACK_CYC.valid))
        else $error("vector base bits wrong");
endmodule

// [src/tbp_pkg.sv]
// Shared constants and types for the timer bus-interface and prescaler block.
// Assumes a single 40 MHz system clock and a 16-bit register port.
package tbp_pkg;
    // ==========================================================
    // Sizes
    localparam int DW = 16;
    localparam int AW = 8;
    localparam int NSUB = 4;
    localparam int NTB = 4;
    localparam int CNT_W = 8;
    localparam int TAP_N = 7;
    localparam logic [3:0] PSEL_BASE = 4'h5;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_READOUT = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    localparam logic [7:0] OFS_TEST = 8'h0A;
    localparam logic [7:0] OFS_RSV0 = 8'h0C;
    localparam logic [7:0] OFS_RSV1 = 8'h0E;
    localparam logic [7:0] OFS_EXTSRC = 8'h10;
    // ==========================================================
    // Field positions, masks and reset values
    localparam int CFG_SEL_LO = 0;
    localparam int CFG_SEL_HI = 5;
    localparam int CFG_ARB_LSB = 8;
    localparam int CFG_VEC_LSB = 11;
    localparam logic [15:0] CFG_WMASK = 16'h1F21;
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam int CTL_RUN = 3;
    localparam int CTL_RATIO = 2;
    localparam int CTL_PSEL_LSB = 0;
    localparam logic [3:0] CTL_RST = 4'h0;
    localparam logic [15:0] READOUT_RST = 16'h0000;
    localparam logic EXT_RST = 1'h0;
    // ==========================================================
    // Types
    typedef struct packed {
        logic [1:0] pend;
        logic [2:0] level;
        logic arb_hi;
        logic [5:0] vec;
    } tbp_sub_t;
    typedef struct packed {
        logic valid;
        logic [2:0] level;
        logic [3:0] arb_num;
    } tbp_ackcyc_t;
    typedef struct packed {
        logic hit;
        logic [7:0] vector;
        logic [1:0] winner;
    } tbp_resp_t;
    // ==========================================================
    // A submodule requests at a given level
    function automatic logic sub_wants(tbp_sub_t s, logic [2:0] lvl);
        return (|s.pend) && (s.level == lvl) && (lvl != 3'h0);
    endfunction
endpackage

// [src/tbp_prescaler.sv]
// Prescaler divider chain producing single-cycle tap enables.
// Assumes run, ratio and freeze are already in the system clock domain.
module tbp_prescaler import tbp_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic ratio3,
    input wire logic [1:0] psel,
    input wire logic frozen,
    output logic [5:0] taps
);
    logic [1:0] stage_r, stage_nxt;
    logic [CNT_W-1:0] chain_r, chain_nxt;
    logic stage_end, tick;

    function automatic logic low_ones(logic [CNT_W-1:0] v, logic [3:0] n);
        logic [CNT_W:0] m;
        m = (9'h001 << n) - 9'h001;
        return (v & m[CNT_W-1:0]) == m[CNT_W-1:0];
    endfunction

    // ==========================================================
    // Divider state
    always_comb begin
        stage_end = ratio3 ? (stage_r >= 2'h2) : (stage_r >= 2'h1);
        tick = run && !frozen && stage_end;
        stage_nxt = stage_r;
        chain_nxt = chain_r;
        if (!run) begin
            stage_nxt = 2'h0;
            chain_nxt = '0;
        end else if (!frozen) begin
            stage_nxt = stage_end ? 2'h0 : stage_r + 2'h1;
            if (stage_end) begin
                chain_nxt = chain_r + 8'h01;
            end
        end
        taps[0] = tick;
        for (int k = 1; k < 5; k++) begin
            taps[k] = tick && low_ones(chain_r, 4'(k));
        end
        taps[5] = tick && low_ones(chain_r, PSEL_BASE + {2'h0, psel});
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage_r <= 2'h0;
            chain_r <= '0;
        end else begin
            stage_r <= stage_nxt;
            chain_r <= chain_nxt;
        end
    end

    a_freeze_holds_chain: assert property (@(posedge clk) disable iff (!reset_n)
        (run && frozen) ##1 run |-> $stable(chain_r) && $stable(stage_r))
        else $error("prescaler moved while frozen");
endmodule

// [src/tbp_arbiter.sv]
// Picks the responding submodule during an interrupt acknowledge cycle.
// Purely combinational; the caller registers the answer.
module tbp_arbiter import tbp_pkg::*; (
    input tbp_sub_t [NSUB-1:0] subs,
    input tbp_ackcyc_t ack_cyc,
    input wire logic [2:0] arb_id,
    input wire logic [1:0] vec_base,
    output tbp_resp_t resp
);
    // ==========================================================
    // Lowest address wins; cause 0 outranks cause 1
    always_comb begin
        resp = '0;
        for (int i = NSUB - 1; i >= 0; i--) begin
            if (ack_cyc.valid && arb_id != 3'h0 && sub_wants(subs[i], ack_cyc.level)
                && ack_cyc.arb_num == {subs[i].arb_hi, arb_id}) begin
                resp.hit = 1'b1;
                resp.winner = 2'(i);
                resp.vector = {vec_base, subs[i].vec[5:1], !subs[i].pend[0]};
            end
        end
    end
endmodule

// [tb/tbp_imb_master.sv]
// Register-port master and interrupt acknowledge source facing the timer block.
// Assumes the caller runs one transfer at a time; signals move just after rising edges.
module tbp_bus_master import tbp_pkg::*; (
    input wire logic clk,
    input wire logic [DW-1:0] rdata,
    input tbp_resp_t resp,
    output logic [AW-1:0] addr,
    output logic [DW-1:0] wdata,
    output logic wr,
    output logic rd,
    output tbp_ackcyc_t ack_cyc
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr = 8'hFF;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        ack_cyc = '0;
    end
    // Released lines show the inverse of the last value
    task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
    // Write immediately followed by a read of the same location, no gap
    task automatic wr_rd(input logic [AW-1:0] a, input logic [DW-1:0] d,
        output logic [DW-1:0] q);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        #1;
        q = rdata;
    endtask
    task automatic ack(input logic [2:0] lvl, input logic [3:0] num, output tbp_resp_t r);
        @(posedge clk);
        ack_cyc <= '{1'b1, lvl, num};
        @(posedge clk);
        ack_cyc <= '{1'b0, ~lvl, ~num};
        #1;
        r = resp;
    endtask
endmodule

// [tb/tb_timer_bus_interface_prescaler.sv]
// Self-checking bench for the timer bus interface and prescaler.
// Assumes the register-port master model and a 40 MHz clock.
module tb_timer_bus_interface_prescaler import tbp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, wr, rd, freeze, test_mode, ext;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata, rdata;
    logic [NTB-1:0][DW-1:0] tb_bus;
    tbp_sub_t [NSUB-1:0] sub;
    tbp_ackcyc_t ack_cyc;
    logic [TAP_N-1:0] taps;
    logic [6:0] irq;
    tbp_resp_t resp;
    int err_total, n_checks;
    tbp_top dut (.CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .FREEZE(freeze), .TEST_MODE(test_mode), .EXT_CLK_IN(ext),
        .TB_BUS(tb_bus), .SUB(sub), .ACK_CYC(ack_cyc), .TAPS(taps), .IRQ(irq), .RESP(resp));
    tbp_bus_master bus (.clk(clk), .rdata(rdata), .resp(resp), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .ack_cyc(ack_cyc));
    always #12.5 clk = ~clk;
    // ==========================================================
    // Helpers
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic quiet(input int n, input string what);
        logic [5:0] seen;
        seen = '0;
        repeat (n) begin
            @(posedge clk);
            #1;
            seen = seen | taps[5:0];
        end
        chk(what, 16'h0000, {10'h000, seen});
    endtask
    task automatic tap_gap(input int k, input logic [15:0] exp);
        int n;
        n = 0;
        // Look at the taps launched by the current edge, as the loop below does
        #1;
        while (taps[k] !== 1'b1 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (taps[k] !== 1'b1 && n < 2000);
        chk("tap gap", exp, 16'(n));
    endtask
    task automatic ext_pulse(input string what);
        logic seen;
        seen = 1'b0;
        repeat (8) begin
            @(posedge clk);
            #1;
            seen = seen | taps[6];
        end
        chk(what, 16'h0001, {15'h0000, seen});
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset_values();
        logic [15:0] d;
        bus.rd_reg(OFS_CONFIG, d);
        chk("config reset", 16'h0000, d);
        bus.rd_reg(OFS_READOUT, d);
        chk("readout reset", 16'h0000, d);
        bus.rd_reg(OFS_CONTROL, d);
        chk("control reset", 16'h0000, d);
        quiet(40, "taps stopped");
    endtask
    task automatic t_registers();
        logic [15:0] d;
        logic [7:0] a[4] = '{OFS_TEST, OFS_RSV0, OFS_RSV1, 8'h20};
        foreach (a[i]) begin
            bus.wr_reg(a[i], 16'hFFFF);
            bus.rd_reg(a[i], d);
            chk("reserved location", 16'h0000, d);
        end
        bus.wr_rd(OFS_CONTROL, 16'hFFFF, d);
        chk("control bits", 16'h000F, d);
        bus.wr_reg(OFS_CONTROL, 16'h0000);
        bus.wr_reg(OFS_CONFIG, 16'hFFFF);
        bus.rd_reg(OFS_CONFIG, d);
        chk("config bits", 16'h1F21, d);
        bus.wr_reg(OFS_CONFIG, 16'h0000);
    endtask
    task automatic t_readout();
        logic [15:0] d;
        @(posedge clk);
        for (int c = 0; c < 4; c++) begin
            tb_bus[c] <= 16'hA0F0 + 16'(c);
        end
        for (int c = 0; c < 4; c++) begin
            bus.wr_reg(OFS_CONFIG, {10'h000, c[1], 4'h0, c[0]});
            bus.rd_reg(OFS_READOUT, d);
            chk("readout", 16'hA0F0 + 16'(c), d);
        end
        bus.wr_reg(OFS_READOUT, 16'h5555);
        bus.rd_reg(OFS_READOUT, d);
        chk("readout after write", 16'hA0F3, d);
        @(posedge clk);
        test_mode <= 1'b1;
        repeat (3) @(posedge clk);
        bus.wr_reg(OFS_READOUT, 16'h5555);
        bus.rd_reg(OFS_READOUT, d);
        chk("readout test write", 16'h5555, d);
        @(posedge clk);
        test_mode <= 1'b0;
        repeat (3) @(posedge clk);
        bus.rd_reg(OFS_READOUT, d);
        chk("readout live again", 16'hA0F3, d);
    endtask
    task automatic t_taps();
        logic [15:0] base;
        for (int r = 0; r < 2; r++) begin
            for (int p = 0; p < 4; p++) begin
                base = (r == 1) ? 16'h0003 : 16'h0002;
                bus.wr_reg(OFS_CONTROL, 16'h0000);
                bus.wr_reg(OFS_CONTROL, {12'h000, 1'b1, r[0], p[1:0]});
                for (int k = 0; k < ((p == 0) ? 5 : 0); k++) begin
                    tap_gap(k, base << k);
                end
                tap_gap(5, (base << 5) << p);
            end
        end
    endtask
    task automatic t_freeze();
        logic [15:0] d;
        bus.wr_reg(OFS_CONTROL, 16'h0008);
        @(posedge clk);
        freeze <= 1'b1;
        repeat (4) @(posedge clk);
        quiet(100, "taps in freeze");
        bus.wr_reg(OFS_CONTROL, 16'h000C);
        bus.rd_reg(OFS_CONTROL, d);
        chk("control in freeze", 16'h000C, d);
        @(posedge clk);
        freeze <= 1'b0;
        tap_gap(0, 16'h0003);
    endtask
    task automatic t_irq_ack();
        tbp_resp_t r;
        @(posedge clk);
        sub[0] <= '{2'b01, 3'h3, 1'b0, 6'h3F};
        sub[1] <= '{2'b10, 3'h3, 1'b1, 6'h2A};
        sub[2] <= '{2'b01, 3'h3, 1'b1, 6'h10};
        sub[3] <= '{2'b00, 3'h7, 1'b1, 6'h01};
        repeat (2) @(posedge clk);
        #1;
        chk("irq lines", 16'h0004, {9'h000, irq});
        bus.wr_reg(OFS_CONFIG, 16'h1500);
        bus.ack(3'h3, 4'hD, r);
        chk("hit", 16'h0001, {15'h0000, r.hit});
        chk("winner", 16'h0001, {14'h0000, r.winner});
        chk("vector", 16'h00AB, {8'h00, r.vector});
        for (int b = 0; b < 4; b++) begin
            bus.wr_reg(OFS_CONFIG, {3'h0, b[1:0], 3'h5, 8'h00});
            bus.ack(3'h3, 4'h5, r);
            chk("vector base", {8'h00, b[1:0], 6'h3E}, {8'h00, r.vector});
        end
        bus.ack(3'h4, 4'h5, r);
        chk("hit other level", 16'h0000, {15'h0000, r.hit});
        bus.wr_reg(OFS_CONFIG, 16'h1000);
        bus.ack(3'h3, 4'h5, r);
        chk("hit arb zero", 16'h0000, {15'h0000, r.hit});
    endtask
    task automatic t_ext();
        @(posedge clk);
        ext <= 1'b1;
        ext_pulse("ext rising");
        bus.wr_reg(OFS_EXTSRC, 16'h0001);
        @(posedge clk);
        ext <= 1'b0;
        ext_pulse("ext falling");
    endtask
    // ==========================================================
    // Run control
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        freeze = 1'b0;
        test_mode = 1'b0;
        ext = 1'b0;
        tb_bus = '0;
        sub = '0;
        err_total = 0;
        n_checks = 0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        t_reset_values();
        t_registers();
        t_readout();
        t_taps();
        t_freeze();
        t_irq_ack();
        t_ext();
        complete_run();
    end
    // Tests take under 10000 cycles; give up after 60000
    initial begin
        #1500000;
        err_total++;
        complete_run();
    end
endmodule
